// ---- inc/host_port_pkg.sv ----
// constants shared by the host register port and its testbench
// assumes a single 250 MHz clock and synchronous host pins
//
// What this block does
// - interrupt output pulled low while any unmasked source event is pending
// - interrupt stays low until every pending unmasked source is acknowledged
// - no register read or write is accepted unless chip select is low
// - chip select first seen high after power-up clears internal test modes
// - data bus driven with addressed register while read strobe and select low
// - one eight-bit bidirectional data bus serves reads and writes
// - write captured on rising edge of write strobe OR chip select
// - address latch transparent while latch enable high, holds while low
// - active-low hardware reset clears the port asynchronously
package host_port_pkg;

	localparam int          DATA_WIDTH   = 8;
	localparam int          ADDR_WIDTH   = 8;
	localparam int          IRQ_SOURCES  = 8;
	localparam logic [7:0]  DATA_RESET   = 8'h00;
	localparam logic [7:0]  ADDR_RESET   = 8'h00;
	// register index holding the interrupt mask, one bit per source
	localparam logic [7:0]  MASK_ADDR    = 8'h01;
	// register index reading the pending source flags
	localparam logic [7:0]  PEND_ADDR    = 8'h02;
	localparam logic [7:0]  MASK_RESET   = 8'h00;

	typedef enum logic [2:0] {
		IDLE_ST  = 3'b001,
		WRITE_ST = 3'b010,
		READ_ST  = 3'b100
	} access_state_type;

endpackage : host_port_pkg

// ---- rtl/reg_store.sv ----
// small register memory behind the host port
// assumes one write port and one read port, read data registered
`timescale 1ns/1ps
module reg_store #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     resetn,
	// write port
	input  wire logic                     writeEn,
	input  wire logic [$clog2(DEPTH)-1:0] writeAddr,
	input  wire logic [WIDTH-1:0]         writeData,
	// read port
	input  wire logic [$clog2(DEPTH)-1:0] readAddr,
	output logic      [WIDTH-1:0]         readData
);

	logic [WIDTH-1:0] mem [DEPTH];

	// storage write; memory content is not reset, only the read register
	always_ff @(posedge clk) begin
		if (writeEn) begin
			mem[writeAddr] <= writeData;
		end
	end

	// registered read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			readData <= '0;
		end else begin
			readData <= mem[readAddr];
		end
	end

endmodule : reg_store

// ---- rtl/host_register_port_irq.sv ----
// eight-bit strobe-timed host register port with open-drain interrupt
// assumes host pins already synchronous to clk; board resolves tri-state bus
`timescale 1ns/1ps
module host_register_port_irq #(
	parameter int SOURCES = host_port_pkg::IRQ_SOURCES
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// host strobes and address
	input  wire logic               chipSelLow,
	input  wire logic               readStrobeLow,
	input  wire logic               writeStrobeLow,
	input  wire logic               addrLatchEn,
	input  wire logic [7:0]         addr,
	// bidirectional data bus split into three signals
	input  wire logic [7:0]         dataIn,
	output logic      [7:0]         dataOut,
	output logic                    dataOe,
	// interrupt sources and acknowledge
	input  wire logic [SOURCES-1:0] srcEvent,
	input  wire logic [SOURCES-1:0] srcAck,
	// open-drain interrupt: drive low when enabled
	output logic                    irqOutLow,
	output logic                    irqOe,
	// test mode status
	output logic                    testMode
);

	logic [7:0]               latchedAddr;
	logic [7:0]               latchedAddrW;
	logic [7:0]               accessAddr;
	logic [7:0]               writeData;
	logic                     writeActive;
	logic                     writeEdge;
	logic                     readActive;
	logic [7:0]               storeData;
	logic [SOURCES-1:0]       pending;
	logic [SOURCES-1:0]       irqMask;
	logic                     irqAny;
	logic                     seenCsHigh;
	host_port_pkg::access_state_type state;
	host_port_pkg::access_state_type next_state;

	// address latch: transparent while enable high, else held
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latchedAddr <= host_port_pkg::ADDR_RESET;
		end else if (addrLatchEn) begin
			latchedAddr <= addr;
		end
	end
	assign accessAddr = addrLatchEn ? addr : latchedAddr;

	// access decode; a dead chip select blocks both strobes
	assign writeActive = !writeStrobeLow && !chipSelLow;
	assign readActive  = !readStrobeLow && !chipSelLow;

	// state tracks strobe phases so a write lands on the OR-edge
	always_comb begin
		next_state = state;
		case (state)
			host_port_pkg::IDLE_ST: begin
				if (writeActive) begin
					next_state = host_port_pkg::WRITE_ST;
				end else if (readActive) begin
					next_state = host_port_pkg::READ_ST;
				end
			end
			host_port_pkg::WRITE_ST: begin
				if (!writeActive) begin
					next_state = host_port_pkg::IDLE_ST;
				end
			end
			host_port_pkg::READ_ST: begin
				if (!readActive) begin
					next_state = host_port_pkg::IDLE_ST;
				end
			end
			default: begin
				next_state = host_port_pkg::IDLE_ST;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= host_port_pkg::IDLE_ST;
		end else begin
			state <= next_state;
		end
	end

	// data is tracked during the strobe and committed when strobe or select rises
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			writeData <= host_port_pkg::DATA_RESET;
		end else if (writeActive) begin
			writeData <= dataIn;
		end
	end
	assign writeEdge = (state == host_port_pkg::WRITE_ST) && !writeActive;

	reg_store #(
		.WIDTH (8),
		.DEPTH (256)
	) u_store (
		.clk       (clk),
		.resetn    (resetn),
		.writeEn   (writeEdge),
		.writeAddr (latchedAddrW),
		.writeData (writeData),
		.readAddr  (accessAddr),
		.readData  (storeData)
	);

	// write address held through the strobe so the edge uses the access address
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latchedAddrW <= host_port_pkg::ADDR_RESET;
		end else if (writeActive) begin
			latchedAddrW <= accessAddr;
		end
	end

	// mask register shadowed in flops so it steers the interrupt
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irqMask <= SOURCES'(host_port_pkg::MASK_RESET);
		end else if (writeEdge && latchedAddrW == host_port_pkg::MASK_ADDR) begin
			irqMask <= writeData[SOURCES-1:0];
		end
	end

	// sticky source flags; a new event beats a same-cycle acknowledge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pending <= '0;
		end else begin
			pending <= srcEvent | (pending & ~srcAck);
		end
	end
	assign irqAny = |(pending & irqMask);

	// open-drain interrupt: output low level, enable while asserted
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irqOe <= 1'b0;
		end else begin
			irqOe <= irqAny;
		end
	end
	assign irqOutLow = 1'b0;

	// test modes stay on from power-up until chip select is seen high
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seenCsHigh <= 1'b0;
		end else if (chipSelLow) begin
			seenCsHigh <= 1'b1;
		end
	end
	assign testMode = !seenCsHigh;

	// read data: status addresses override the memory word
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dataOut <= host_port_pkg::DATA_RESET;
		end else if (accessAddr == host_port_pkg::PEND_ADDR) begin
			dataOut <= 8'(pending);
		end else if (accessAddr == host_port_pkg::MASK_ADDR) begin
			dataOut <= 8'(irqMask);
		end else begin
			dataOut <= storeData;
		end
	end

	// bus driven only during a selected read, released otherwise
	assign dataOe = readActive;

	// assertions
	sequence readOn_s;
		!readStrobeLow && !chipSelLow;
	endsequence

	// unmasked event, then a mask that did not move under it
	sequence srcRaise_s;
		|(srcEvent & irqMask) ##1 $stable(irqMask);
	endsequence

	busDrive_a: assert property (@(posedge clk) disable iff (!resetn)
		readOn_s |-> dataOe) else $error("bus not driven during read");
	busRelease_a: assert property (@(posedge clk) disable iff (!resetn)
		(readStrobeLow || chipSelLow) |-> !dataOe) else $error("bus driven outside read");
	noSelWrite_a: assert property (@(posedge clk) disable iff (!resetn)
		chipSelLow[*2] |-> !writeEdge) else $error("write without select");
	irqSet_a: assert property (@(posedge clk) disable iff (!resetn)
		srcRaise_s |-> ##1 irqOe) else $error("irq missed");
	irqHold_a: assert property (@(posedge clk) disable iff (!resetn)
		irqAny |=> irqOe) else $error("irq released early");
	testClear_a: assert property (@(posedge clk) disable iff (!resetn)
		chipSelLow |=> !testMode) else $error("test mode not cleared");
	addrHold_a: assert property (@(posedge clk) disable iff (!resetn)
		!addrLatchEn |=> $stable(latchedAddr)) else $error("address moved while latched");
	writeEdge_a: assert property (@(posedge clk) disable iff (!resetn)
		writeEdge |-> $past(writeActive)) else $error("write edge without strobe");

endmodule : host_register_port_irq

// ---- tb/host_model.sv ----
// host processor model for the register port, one byte access at a time
// assumes the port samples its pins on the rising edge of clk
`timescale 1ns/1ps
module host_model (
	// clock
	input  wire logic       clk,
	// host pins
	output logic            chipSelLow,
	output logic            readStrobeLow,
	output logic            writeStrobeLow,
	output logic            addrLatchEn,
	output logic [7:0]      addr,
	output logic [7:0]      dataIn,
	// device side of the bus
	input  wire logic [7:0] dataOut,
	input  wire logic       dataOe
);
	logic [7:0] wrData  = 8'h00;
	logic       wrDrive = 1'b0;
	logic [7:0] lastBus = 8'h00;
	// select held low from power-up so the test mode is seen first
	initial begin
		chipSelLow = 1'b0;
		readStrobeLow = 1'b1;
		writeStrobeLow = 1'b1;
		addrLatchEn = 1'b1;
		addr = 8'h00;
	end
	// a released bus shows the inverse of its last level, never a kind value
	assign dataIn = dataOe ? dataOut : (wrDrive ? wrData : lastBus);
	always @(posedge clk) lastBus <= ~dataIn;
	// address is latched and then scrambled, so a leaky latch reads wrong
	task automatic access(input logic w, input logic sel, input logic [7:0] a,
			input logic [7:0] d, output logic [7:0] q, output logic oe);
		@(posedge clk);
		chipSelLow <= sel;
		addr <= a;
		addrLatchEn <= 1'b1;
		wrData <= d;
		wrDrive <= w;
		readStrobeLow <= w;
		writeStrobeLow <= ~w;
		@(posedge clk);
		addrLatchEn <= 1'b0;
		addr <= ~a;
		repeat (3) @(posedge clk);
		q = dataOut;
		oe = dataOe;
		chipSelLow <= 1'b1;
		readStrobeLow <= 1'b1;
		writeStrobeLow <= 1'b1;
		wrDrive <= 1'b0;
		@(posedge clk);
	endtask : access
endmodule : host_model

// ---- tb/host_register_port_irq_tb.sv ----
// self-checking bench for the host register port and its interrupt
// assumes the host model drives all bus pins; sources driven here
`timescale 1ns/1ps
module host_register_port_irq_tb;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic [7:0] srcEvent = 8'h00;
	logic [7:0] srcAck = 8'h00;
	logic       chipSelLow, readStrobeLow, writeStrobeLow, addrLatchEn, dataOe;
	logic       irqOutLow, irqOe, testMode, oe;
	logic [7:0] addr, dataIn, dataOut, q, d;
	logic [7:0] mem [256];
	logic [7:0] adr [8];
	int         errors = 0;
	int         tests_run = 0;
	int         seed = 32'hff87;
	always #2 clk = ~clk;
	host_model host (.clk, .chipSelLow, .readStrobeLow, .writeStrobeLow,
		.addrLatchEn, .addr, .dataIn, .dataOut, .dataOe);
	host_register_port_irq uut (.clk, .resetn, .chipSelLow, .readStrobeLow,
		.writeStrobeLow, .addrLatchEn, .addr, .dataIn, .dataOut, .dataOe,
		.srcEvent, .srcAck, .irqOutLow, .irqOe, .testMode);
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// pulse events and acks, then give the registered flag time to settle
	task irq(input logic [7:0] ev, input logic [7:0] ack, input logic e);
		srcEvent <= ev;
		srcAck <= ack;
		@(posedge clk);
		srcEvent <= 8'h00;
		srcAck <= 8'h00;
		repeat (3) @(posedge clk);
		chk("irqOe", {7'h00, e}, {7'h00, irqOe});
		chk("irqOutLow", 8'h00, {7'h00, irqOutLow});
	endtask : irq
	task finish_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// watchdog sized well past the roughly 150 cycles of the sequence
	initial begin
		#40000;
		errors++;
		finish_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		chk("testMode held", 8'h01, {7'h00, testMode});
		// random bytes to random plain addresses, mask and pending avoided
		for (int i = 0; i < 8; i++) begin
			adr[i] = 8'h10 + 8'($unsigned($random(seed)) % 240);
			mem[adr[i]] = $random(seed);
			host.access(1'b1, 1'b0, adr[i], mem[adr[i]], q, oe);
		end
		chk("testMode cleared", 8'h00, {7'h00, testMode});
		// refused: select high on a write and on a read
		host.access(1'b1, 1'b1, adr[7], ~mem[adr[7]], q, oe);
		host.access(1'b0, 1'b1, adr[7], 8'h00, q, oe);
		chk("dataOe deselected", 8'h00, {7'h00, oe});
		for (int i = 7; i >= 0; i--) begin
			host.access(1'b0, 1'b0, adr[i], 8'h00, q, oe);
			chk("read data", mem[adr[i]], q);
			chk("dataOe read", 8'h01, {7'h00, oe});
			chk("dataOe idle", 8'h00, {7'h00, dataOe});
		end
		d = 8'h05;
		host.access(1'b1, 1'b0, host_port_pkg::MASK_ADDR, d, q, oe);
		irq(8'h02, 8'h00, 1'b0);
		irq(8'h05, 8'h00, 1'b1);
		irq(8'h00, 8'h01, 1'b1);
		irq(8'h00, 8'h04, 1'b0);
		irq(8'h01, 8'h02, 1'b1);
		// reset lands between edges and must act at once
		#1 resetn = 1'b0;
		#1 chk("irqOe async", 8'h00, {7'h00, irqOe});
		chk("testMode async", 8'h01, {7'h00, testMode});
		@(posedge clk);
		resetn <= 1'b1;
		host.access(1'b0, 1'b0, host_port_pkg::MASK_ADDR, 8'h00, q, oe);
		chk("mask reset", host_port_pkg::MASK_RESET, q);
		finish_test();
	end
endmodule : host_register_port_irq_tb
